// file: common/ioc_consts.svh
/*
 * Offsets, field positions, reset values and fixed line numbers of the
 * pad control and routing block. Assumes nothing but a plain include.
 */
// What this block does
// - Each pad cell picks clock, clear, tick gate and drive from shared lines.
// - The shared control network carries at most twelve low-skew lines.
// - At most eight drive lines, six tick gates, two clocks, two clears.
// - Lines 0-5 are drives only; other six lines are shared in pairs.
// - Tick gate and drive may come from per-pad logic cells instead.
// - A pad register may also be clocked from either dedicated clock pin.
// - Each line is sourced from a dedicated pin or its row's first cell.
// - Each line has a fixed source row set by the device size.
// - Device-wide reset clears every pad register, overriding all controls.
// - Four shared lines can drive the four low-skew nets.
// - Device-wide drive pin low puts every pad in high impedance.
// - An input pad drives two row channels reachable by the whole row.
// - A row-side output pad takes data from a mux over its row channels.
// - A column-side output pad takes data from a mux over column channels.
// - A column-side input pad drives two channels; each pad sees its own set.
// - Each pad cell has a two-way buffer and one capture or output register.
`ifndef IOC_CONSTS_SVH
`define IOC_CONSTS_SVH

`define IOC_ADDR_CTRL 8'h00
`define IOC_ADDR_LINE_SRC 8'h04
`define IOC_ADDR_NET_SRC 8'h08
`define IOC_ADDR_LINES 8'h0C
`define IOC_ADDR_PAD_REG 8'h10
`define IOC_ADDR_PAD_CFG 8'h40

`define IOC_CTRL_LOCK 0
`define IOC_LINE_SRC_RST 12'h000
`define IOC_NET_SRC_RST 4'h0
`define IOC_PAD_CFG_RST 32'h0000_0000

`define IOC_NUM_LINES 12
`define IOC_NUM_NETS 4
`define IOC_NUM_DED_PINS 6
`define IOC_LINE_SHARED_CLOCK_LINE_0 6
`define IOC_LINE_SHARED_CLOCK_LINE_1 11
`define IOC_LINE_SHARED_CLEAR_LINE_0 8
`define IOC_LINE_SHARED_CLEAR_LINE_1 10
`define IOC_LINE_TICK0 6
`define IOC_LINE_DRV6 7
`define IOC_LINE_DRV7 9
`define IOC_NET_LINES 48'h00B_009_007_006

`define IOC_F_CLK_SEL 0
`define IOC_F_CLR_SEL 2
`define IOC_F_GATE_SEL 4
`define IOC_F_GATE_EN 7
`define IOC_F_GATE_CELL 8
`define IOC_F_DRV_SEL 9
`define IOC_F_DRV_CELL 12
`define IOC_F_DRV_EN 13
`define IOC_F_MODE 14
`define IOC_F_REG_USED 16
`define IOC_F_DATA_SEL 17
`define IOC_F_CHAN_EN 23

`define IOC_ROW_PER_PIN 18
`define IOC_ROW_CHANS 144
`define IOC_COL_PER_PIN 16
`define IOC_COL_CHANS 24
`define IOC_LINE_ROWS 48'h2211_0022_1100
`define IOC_COL_STEP 4

`endif

// file: common/ioc_pkg.sv
/*
 * Types shared by the pad control block and its pad cells.
 * Assumes ioc_consts.svh for the numbers.
 */
package ioc_pkg;
    typedef enum logic [1:0] {
        IOC_MODE_IN = 2'h0,
        IOC_MODE_OUT = 2'h1,
        IOC_MODE_BIDIR = 2'h2,
        IOC_MODE_OFF = 2'h3
    } ioc_mode_e;
    typedef enum logic [1:0] {
        IOC_CLK_LINE0 = 2'h0,
        IOC_CLK_LINE1 = 2'h1,
        IOC_CLK_PIN0 = 2'h2,
        IOC_CLK_PIN1 = 2'h3
    } ioc_clk_sel_e;
    typedef enum logic [1:0] {
        IOC_CLR_NONE = 2'h0,
        IOC_CLR_LINE0 = 2'h1,
        IOC_CLR_LINE1 = 2'h2,
        IOC_CLR_BOTH = 2'h3
    } ioc_clr_sel_e;
    typedef logic [31:0] ioc_word_t;
endpackage : ioc_pkg

// file: hw/ioc_pad_cell.sv
/*
 * One pad cell: the register and the two-way buffer controls.
 * Assumes every select is already resolved to a level on ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module ioc_pad_cell
    import ioc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Resolved controls
    input wire ioc_pkg::ioc_mode_e mode,
    input wire logic reg_used,
    input wire logic clk_level,
    input wire logic gate_ok,
    input wire logic clr,
    input wire logic chip_clr,
    input wire logic drive_ok,
    input wire logic all_drive_n,
    // Data
    input wire logic out_data,
    input wire logic pad_in,
    // Pad and channel side
    output logic pad_o,
    output logic pad_oe,
    output logic reg_val,
    output logic to_chan
);
    import ioc_pkg::*;

    logic clk_prev_q;
    logic reg_q;
    logic pad_o_q;
    logic pad_oe_q;
    logic to_chan_q;
    logic tick;
    logic is_in;

    assign is_in = (mode == IOC_MODE_IN) || (mode == IOC_MODE_BIDIR);
    // The selected clock is a level on ref_clk, so its rising edge is found
    // by comparing with last cycle's value.
    assign tick = clk_level && !clk_prev_q && gate_ok;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_level;
        end
    end

    // One register, either capturing the pad or feeding it.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_q <= 1'b0;
        end else if (chip_clr) begin
            reg_q <= 1'b0;
        end else if (clr) begin
            reg_q <= 1'b0;
        end else if (tick) begin
            reg_q <= (mode == IOC_MODE_IN) ? pad_in : out_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_o_q <= 1'b0;
            pad_oe_q <= 1'b0;
            to_chan_q <= 1'b0;
        end else begin
            pad_o_q <= reg_used ? reg_q : out_data;
            pad_oe_q <= all_drive_n && drive_ok &&
                ((mode == IOC_MODE_OUT) || (mode == IOC_MODE_BIDIR));
            to_chan_q <= is_in ? ((reg_used && mode == IOC_MODE_IN) ?
                reg_q : pad_in) : 1'b0;
        end
    end

    assign pad_o = pad_o_q;
    assign pad_oe = pad_oe_q;
    assign reg_val = reg_q;
    assign to_chan = to_chan_q;
endmodule : ioc_pad_cell
`default_nettype wire

// file: hw/ioc_top.sv
/*
 * Pad control selection and routing: shared control lines, low-skew nets,
 * per-pad control selection and channel multiplexers, Wishbone registers.
 * Assumes a classic Wishbone master on ref_clk and pins from the board.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ioc_consts.svh"
module ioc_top
    import ioc_pkg::*;
#(
    parameter int ROW_PADS = 8,
    parameter int COL_PADS = 2,
    parameter int ROWS = 3,
    parameter int ROW_CHANS = `IOC_ROW_CHANS,
    parameter int ROW_PER_PIN = `IOC_ROW_PER_PIN,
    parameter int COL_CHANS = `IOC_COL_CHANS,
    parameter int COL_PER_PIN = `IOC_COL_PER_PIN,
    parameter logic [47:0] LINE_ROWS = `IOC_LINE_ROWS,
    parameter int NP = ROW_PADS + COL_PADS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire ioc_pkg::ioc_word_t wb_dat_i,
    output logic wb_ack_o,
    output ioc_pkg::ioc_word_t wb_dat_o,
    // Board pins
    input wire logic [5:0] ded_pin_i,
    input wire logic [1:0] clk_pin_i,
    input wire logic chip_rst_pin_n,
    input wire logic chip_drive_pin_n,
    // Pads
    input wire logic [NP-1:0] pad_i,
    output logic [NP-1:0] pad_o,
    output logic [NP-1:0] pad_oe,
    // Logic cell side
    input wire logic [ROWS-1:0] row_first_cell,
    input wire logic [NP-1:0] cell_gate,
    input wire logic [NP-1:0] cell_drive,
    input wire logic [ROW_CHANS-1:0] row_chan,
    input wire logic [COL_CHANS-1:0] col_chan,
    output logic [NP-1:0] pad_to_chan,
    output logic [2*NP-1:0] pad_chan_en,
    output logic [3:0] low_skew_net
);
    import ioc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks.

    if (ROW_PER_PIN > 64 || COL_PER_PIN > 64) begin : g_bad_mux
        $error("Channel mux select is six bits wide.");
    end
    if (ROW_PER_PIN > ROW_CHANS || COL_PER_PIN > COL_CHANS) begin : g_bad_set
        $error("Pad channel set larger than the channel bundle.");
    end
    if (ROWS < 1 || ROWS > 16 || NP > 16 || NP < 1) begin : g_bad_size
        $error("Row count or pad count out of range.");
    end
    if (ROW_PADS > 8 || COL_PADS > 2) begin : g_bad_side
        $error("Too many pads on one side of a channel bundle.");
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    // Channel picked by a pad from its window of the bundle; row windows are disjoint, column windows overlap.
    function automatic int chan_pick(input int base, input int sel,
                                     input int per, input int n);
        int s;
        s = (sel < per) ? sel : 0;
        return (base + s) % n;
    endfunction : chan_pick

    // Line carrying pad drive k (0..7).
    function automatic int drive_line(input logic [2:0] k);
        int r;
        r = int'(k);
        if (k == 3'h6) begin
            r = `IOC_LINE_DRV6;
        end else if (k == 3'h7) begin
            r = `IOC_LINE_DRV7;
        end
        return r;
    endfunction : drive_line

    // Line carrying tick gate k (0..5); out-of-range codes fold to 0.
    function automatic int gate_line(input logic [2:0] k);
        int r;
        r = `IOC_LINE_TICK0;
        if (k < 3'h6) begin
            r = `IOC_LINE_TICK0 + int'(k);
        end
        return r;
    endfunction : gate_line

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [5:0] ded_meta_q;
    logic [5:0] ded_s_q;
    logic [1:0] clkp_meta_q;
    logic [1:0] clkp_s_q;
    logic [1:0] ctl_meta_q;
    logic [1:0] ctl_s_q;
    logic [NP-1:0] pad_meta_q;
    logic [NP-1:0] pad_s_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ded_meta_q <= 6'h00;
            ded_s_q <= 6'h00;
            clkp_meta_q <= 2'h0;
            clkp_s_q <= 2'h0;
            ctl_meta_q <= 2'h3;
            ctl_s_q <= 2'h3;
            pad_meta_q <= '0;
            pad_s_q <= '0;
        end else begin
            ded_meta_q <= ded_pin_i;
            ded_s_q <= ded_meta_q;
            clkp_meta_q <= clk_pin_i;
            clkp_s_q <= clkp_meta_q;
            ctl_meta_q <= {chip_drive_pin_n, chip_rst_pin_n};
            ctl_s_q <= ctl_meta_q;
            pad_meta_q <= pad_i;
            pad_s_q <= pad_meta_q;
        end
    end

    // The board drives the reset pin low to clear the pad registers.
    logic chip_clr;
    assign chip_clr = !ctl_s_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    logic lock_q;
    logic [`IOC_NUM_LINES-1:0] line_src_q;
    logic [`IOC_NUM_NETS-1:0] net_src_q;
    ioc_word_t pad_cfg_q [NP];
    logic ack_q;
    ioc_word_t rdat_q;
    logic wr_go;
    logic cfg_wr;

    // The write lands on the same edge at which the master samples ack.
    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    // Selections are frozen once software sets the lock.
    assign cfg_wr = wr_go && !lock_q;

    function automatic ioc_word_t merge(input ioc_word_t old,
                                        input ioc_word_t nw,
                                        input logic [3:0] sel);
        ioc_word_t r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
        end else if (wr_go && wb_adr_i == `IOC_ADDR_CTRL && wb_sel_i[0] &&
                     wb_dat_i[`IOC_CTRL_LOCK]) begin
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_src_q <= `IOC_LINE_SRC_RST;
            net_src_q <= `IOC_NET_SRC_RST;
        end else if (cfg_wr) begin
            if (wb_adr_i == `IOC_ADDR_LINE_SRC) begin
                line_src_q <= 12'(merge(32'(line_src_q), wb_dat_i,
                                        wb_sel_i));
            end
            if (wb_adr_i == `IOC_ADDR_NET_SRC && wb_sel_i[0]) begin
                net_src_q <= wb_dat_i[3:0];
            end
        end
    end

    for (genvar p = 0; p < NP; p++) begin : g_cfg
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                pad_cfg_q[p] <= `IOC_PAD_CFG_RST;
            end else if (cfg_wr &&
                         wb_adr_i == 8'(`IOC_ADDR_PAD_CFG + 4 * p)) begin
                pad_cfg_q[p] <= merge(pad_cfg_q[p], wb_dat_i, wb_sel_i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared control lines and low-skew nets.

    // Twelve lines only; each is fed from a dedicated pin or from the first
    // cell of its fixed row. A cell in another row is routed onto that row
    // before it arrives here.
    logic [`IOC_NUM_LINES-1:0] lines;
    logic [3:0] net_d;

    for (genvar l = 0; l < `IOC_NUM_LINES; l++) begin : g_line
        localparam int ROW = int'(LINE_ROWS[4*l +: 4]);
        if (ROW >= ROWS) begin : g_bad_row
            $error("Line source row beyond the row count.");
        end
        assign lines[l] = line_src_q[l] ? row_first_cell[ROW]
                                        : ded_s_q[l % `IOC_NUM_DED_PINS];
    end

    // A net taken over by a line ignores its dedicated pin, which the board
    // ties off.
    for (genvar g = 0; g < `IOC_NUM_NETS; g++) begin : g_net
        localparam logic [47:0] NL = `IOC_NET_LINES;
        localparam int LN = int'(NL[12*g +: 12]);
        assign net_d[g] = net_src_q[g] ? lines[LN]
                                       : ded_s_q[g];
    end

    logic [3:0] net_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            net_q <= 4'h0;
        end else begin
            net_q <= net_d;
        end
    end
    assign low_skew_net = net_q;

    ////////////////////////////////////////////////////////////////////////
    // Pad cells with their control and data selection.

    logic [NP-1:0] reg_vals;
    logic [2*NP-1:0] chan_en_q;

    for (genvar p = 0; p < NP; p++) begin : g_pad
        ioc_word_t c;
        ioc_mode_e mode;
        ioc_clk_sel_e csel;
        ioc_clr_sel_e rsel;
        logic clk_level;
        logic gate_ok;
        logic clr;
        logic drive_ok;
        logic out_data;
        int dsel;

        assign c = pad_cfg_q[p];
        assign mode = ioc_mode_e'(c[`IOC_F_MODE +: 2]);
        assign csel = ioc_clk_sel_e'(c[`IOC_F_CLK_SEL +: 2]);
        assign rsel = ioc_clr_sel_e'(c[`IOC_F_CLR_SEL +: 2]);
        assign dsel = int'(c[`IOC_F_DATA_SEL +: 6]);

        // Two shared clocks or two dedicated clock pins.
        always_comb begin
            case (csel)
                IOC_CLK_LINE0: clk_level = lines[`IOC_LINE_SHARED_CLOCK_LINE_0];
                IOC_CLK_LINE1: clk_level = lines[`IOC_LINE_SHARED_CLOCK_LINE_1];
                IOC_CLK_PIN0: clk_level = clkp_s_q[0];
                IOC_CLK_PIN1: clk_level = clkp_s_q[1];
                default: clk_level = 1'b0;
            endcase
        end

        always_comb begin
            case (rsel)
                IOC_CLR_NONE: clr = 1'b0;
                IOC_CLR_LINE0: clr = lines[`IOC_LINE_SHARED_CLEAR_LINE_0];
                IOC_CLR_LINE1: clr = lines[`IOC_LINE_SHARED_CLEAR_LINE_1];
                IOC_CLR_BOTH: clr = lines[`IOC_LINE_SHARED_CLEAR_LINE_0] ||
                                    lines[`IOC_LINE_SHARED_CLEAR_LINE_1];
                default: clr = 1'b0;
            endcase
        end

        // Tick gate and drive: a shared line, or a pad's own logic cell.
        always_comb begin
            if (!c[`IOC_F_GATE_EN]) begin
                gate_ok = 1'b1;
            end else if (c[`IOC_F_GATE_CELL]) begin
                gate_ok = cell_gate[p];
            end else begin
                gate_ok = lines[gate_line(c[`IOC_F_GATE_SEL +: 3])];
            end
        end

        always_comb begin
            if (!c[`IOC_F_DRV_EN]) begin
                drive_ok = 1'b1;
            end else if (c[`IOC_F_DRV_CELL]) begin
                drive_ok = cell_drive[p];
            end else begin
                drive_ok = lines[drive_line(c[`IOC_F_DRV_SEL +: 3])];
            end
        end

        // Output data from this pad's own window of channels.
        if (p < ROW_PADS) begin : g_row
            assign out_data = row_chan[chan_pick(p * ROW_PER_PIN, dsel,
                ROW_PER_PIN, ROW_CHANS)];
        end else begin : g_col
            assign out_data = col_chan[chan_pick((p - ROW_PADS) *
                `IOC_COL_STEP, dsel, COL_PER_PIN, COL_CHANS)];
        end

        ioc_pad_cell u_cell (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .mode(mode),
            .reg_used(c[`IOC_F_REG_USED]),
            .clk_level(clk_level),
            .gate_ok(gate_ok),
            .clr(clr),
            .chip_clr(chip_clr),
            .drive_ok(drive_ok),
            .all_drive_n(ctl_s_q[1]),
            .out_data(out_data),
            .pad_in(pad_s_q[p]),
            .pad_o(pad_o[p]),
            .pad_oe(pad_oe[p]),
            .reg_val(reg_vals[p]),
            .to_chan(pad_to_chan[p])
        );

        // An input pad offers its value on two channels of its row or
        // column; each enable is a separate configuration bit.
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                chan_en_q[2*p +: 2] <= 2'h0;
            end else if (mode == IOC_MODE_IN || mode == IOC_MODE_BIDIR) begin
                chan_en_q[2*p +: 2] <= c[`IOC_F_CHAN_EN +: 2];
            end else begin
                chan_en_q[2*p +: 2] <= 2'h0;
            end
        end
    end

    assign pad_chan_en = chan_en_q;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone answer: ack one cycle after the request, then dropped.

    function automatic ioc_word_t read_mux(input logic [7:0] a);
        ioc_word_t r;
        r = 32'h0000_0000;
        case (a)
            `IOC_ADDR_CTRL: r[`IOC_CTRL_LOCK] = lock_q;
            `IOC_ADDR_LINE_SRC: r[11:0] = line_src_q;
            `IOC_ADDR_NET_SRC: r[3:0] = net_src_q;
            `IOC_ADDR_LINES: r = {net_q, 16'h0000, lines};
            `IOC_ADDR_PAD_REG: r[NP-1:0] = reg_vals;
            default: begin
                for (int p = 0; p < NP; p++) begin
                    if (a == 8'(`IOC_ADDR_PAD_CFG + 4 * p)) begin
                        r = pad_cfg_q[p];
                    end
                end
            end
        endcase
        return r;
    endfunction : read_mux

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdat_q <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i) begin
            rdat_q <= read_mux(wb_adr_i);
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
endmodule : ioc_top
`default_nettype wire

// file: sim/ioc_board.sv
/* Board model at the pins. Assumes the bench gives its wishes. */
`timescale 1ns/10ps
`default_nettype none
module ioc_board (
    // From the device and the bench
    input wire logic ref_clk,
    input wire logic [9:0] pad_o,
    input wire logic [9:0] pad_oe,
    input wire logic [9:0] ext,
    input wire logic [9:0] ext_en,
    input wire logic rst_req,
    input wire logic [3:0] net_int,
    input wire logic [5:0] want,
    // To the device
    output logic [9:0] pad_i,
    output logic chip_rst_pin_n,
    output logic [5:0] ded_pin_i
);
    logic [9:0] wig = 10'h000;
    always @(posedge ref_clk) wig <= ~wig;
    // A pad nobody drives floats, so it shows a level that moves.
    assign pad_i = (pad_oe & pad_o) |
        (~pad_oe & ((ext_en & ext) | (~ext_en & wig)));
    assign chip_rst_pin_n = !rst_req;
    // A pin whose net is driven inside is grounded, never left open.
    assign ded_pin_i = {want[5:4], want[3:0] & ~net_int};
endmodule : ioc_board
`default_nettype wire

// file: sim/ioc_top_monitor.sv
/* Checker on the ioc_top ports. Assumes the bind at the foot. */
`timescale 1ns/10ps
`default_nettype none
module ioc_top_monitor #(parameter int NP = 10) (
    // Clock, reset and bus
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire ioc_pkg::ioc_word_t wb_dat_o,
    // Board pins and pads
    input wire logic chip_rst_pin_n,
    input wire logic chip_drive_pin_n,
    input wire logic [NP-1:0] pad_o,
    input wire logic [NP-1:0] pad_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("request not acked");
    a_ack_cause: assert property ($rose(wb_ack_o)
        |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_no_stray: assert property (!(wb_cyc_i && wb_stb_i)
        |=> !wb_ack_o) else $error("ack while idle");
    a_dat_holds: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i)
        |=> $stable(wb_dat_o)) else $error("read data moved");
    a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        && !wb_we_i && wb_adr_i == 8'h20 |=> wb_dat_o == '0)
        else $error("unmapped read not zero");
    a_drive_off: assert property (!chip_drive_pin_n [*5]
        |-> pad_oe == '0) else $error("pad driven while drive pin low");
    a_rst_clears: assert property (!chip_rst_pin_n [*5] ##0
        (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == 8'h10)
        |=> wb_dat_o[NP-1:0] == '0) else $error("pad register not cleared");
endmodule : ioc_top_monitor
bind ioc_top ioc_top_monitor #(.NP(NP)) ioc_top_monitor_inst (.ref_clk,
    .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .wb_dat_o,
    .chip_rst_pin_n, .chip_drive_pin_n, .pad_o, .pad_oe);
`default_nettype wire

// file: sim/ioc_top_test.sv
/* Bench for ioc_top with a shadow model. Assumes board and checker. */
`timescale 1ns/10ps
`default_nettype none
`include "ioc_consts.svh"
module ioc_top_test;
    import ioc_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic ack, drv_n = 1'b1, rst_req = 1'b0, crst_n, b, b2;
    logic [7:0] adr = 8'h00, rnd = 8'h47;
    ioc_word_t dat = '0, dat_o, rdat, c, mdl [int];
    logic [5:0] want = '0, ded;
    logic [1:0] clk_pin = '0;
    logic [3:0] net_int = '0, net;
    logic [2:0] rfc = '0;
    logic [9:0] ext = '0, ext_en = '0, pad_i, pad_o, pad_oe, to_chan;
    logic [19:0] chan_en;
    logic [143:0] row_chan = '0;
    logic [23:0] col_chan = '0;
    logic [11:0] src = '0;
    int fail_count = 0, compares = 0, cycles = 0, sel;
    bit lock = 0;
    always #10 ref_clk = ~ref_clk;
    ioc_top ioc_top_inst (.ref_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_ack_o(ack), .wb_dat_o(dat_o), .ded_pin_i(ded),
        .clk_pin_i(clk_pin), .chip_rst_pin_n(crst_n),
        .chip_drive_pin_n(drv_n), .pad_i, .pad_o, .pad_oe,
        .row_first_cell(rfc), .cell_gate(10'h000), .cell_drive(10'h000),
        .row_chan, .col_chan, .pad_to_chan(to_chan),
        .pad_chan_en(chan_en), .low_skew_net(net));
    ioc_board ioc_board_inst (.ref_clk, .pad_o, .pad_oe, .ext, .ext_en,
        .rst_req, .net_int, .want, .pad_i, .chip_rst_pin_n(crst_n),
        .ded_pin_i(ded));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    function automatic logic ln(input int i);
        return src[i] ? rfc[(`IOC_LINE_ROWS >> (4 * i)) & 48'hF] : ded[i % 6];
    endfunction : ln
    task automatic chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input ioc_word_t d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge ref_clk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 20) fail_count++;
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task automatic cfg(input logic [7:0] a, input ioc_word_t d);
        bus(1'b1, a, d);
        if (!lock) mdl[a] = d & (a == 8'h04 ? 32'hFFF : a == 8'h08 ? 32'hF
            : 32'h01FF_FFFF);
        bus(1'b0, a, '0);
        chk("reg", rdat, mdl[a]);
    endtask : cfg
    task automatic pulse();
        clk_pin[0] <= 1'b1;
        repeat (5) @(posedge ref_clk);
        clk_pin[0] <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : pulse
    task automatic end_sim();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        bus(1'b0, 8'h04, '0);
        chk("line_src", rdat, 32'h0);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        bus(1'b0, 8'h20, '0);
        chk("unmapped", rdat, 32'h0);
        ext_en <= 10'h002;
        cfg(8'h44, 32'h0180_0000);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            sel = rnd % 16;
            b = rnd[0];
            b2 = rnd[1];
            c = 32'h0001_4002 | (32'(sel) << 17);
            cfg(8'h40, c);
            cfg(8'h60, c);
            row_chan <= 144'(b) << sel;
            col_chan <= 24'(b2) << sel;
            ext[1] <= rnd[2];
            pulse();
            chk("row_out", pad_o[0], b);
            chk("col_out", pad_o[8], b2);
            chk("oe", {pad_oe[8], pad_oe[0]}, 2'b11);
            chk("in_chan", {chan_en[3:2], to_chan[1]}, {2'b11, rnd[2]});
        end
        cfg(8'h40, c | 32'h80);
        row_chan <= ~row_chan;
        pulse();
        chk("gated", pad_o[0], b);
        want <= 6'h01;
        pulse();
        chk("gate_on", pad_o[0], !b);
        cfg(8'h40, c | 32'h180);
        row_chan <= ~row_chan;
        pulse();
        chk("cell_gate", pad_o[0], !b);
        cfg(8'h40, c | 32'h4);
        want <= 6'h04;
        repeat (5) @(posedge ref_clk);
        chk("clear", pad_o[0], 1'b0);
        want <= 6'h00;
        row_chan <= '1;
        pulse();
        rst_req <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("chip_rst", pad_o[0], 1'b0);
        bus(1'b0, 8'h10, '0);
        chk("pad_regs", rdat, 32'h0);
        rst_req <= 1'b0;
        bus(1'b0, 8'h40, '0);
        chk("cfg_kept", rdat, mdl[8'h40]);
        drv_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("tristate", pad_oe, 10'h000);
        drv_n <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            want <= rnd[5:0];
            rfc <= rnd[7:5];
            net_int <= {4{k[0]}};
            src = k ? 12'hFFF : 12'h000;
            cfg(8'h04, 32'(src));
            cfg(8'h08, k ? 32'hF : 32'h0);
            repeat (4) @(posedge ref_clk);
            c = '0;
            for (int i = 0; i < 12; i++) c[i] = ln(i);
            c[31:28] = k ? {c[11], c[9], c[7], c[6]} : ded[3:0];
            chk("net", net, c[31:28]);
            bus(1'b0, 8'h0C, '0);
            chk("lines", rdat, c);
        end
        bus(1'b1, 8'h00, 32'h1);
        lock = 1;
        cfg(8'h04, 32'h0);
        end_sim();
    end
endmodule : ioc_top_test
`default_nettype wire
